// >>> logic/rhg_gate.sv
// Health gated random octet source with its output buffer
//
// Summary of operation
// - Check for dead source right at start
// - Dead source at start blocks all output
// - Drop values built from post-failure raw bits
// - Statistical test at start and while running
// - No output before power-up test passes
// - Statistical defect stops all output
// - Statistical test runs continuously, window by window
// - Defects caught by the end of the first whole window after onset
// - Random output delivered as octets
// - Software starts failure test, result flag reported

// Simple synchronous FIFO with valid and ready on both sides
module rhg_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             flush_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];   // Storage array
	logic [AW-1:0]    wptr_r;          // Next write slot
	logic [AW-1:0]    rptr_r;          // Next read slot
	logic [AW:0]      count_r;         // Words held
	logic             push;            // Word accepted this cycle
	logic             pop;             // Word drained this cycle

	// Honest full and empty from the occupancy count
	assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (count_r != '0);
	assign push         = wr_valid_in && wr_ready_out && !flush_in;
	assign pop          = rd_valid_out && rd_ready_in && !flush_in;
	assign rd_data_out  = mem_r[rptr_r];

	// Storage write, no reset needed on data
	always_ff @(posedge sys_clk_in)
	begin
		if (push)
			mem_r[wptr_r] <= wr_data_in;
	end

	// Pointers and count; flush empties the buffer at once
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			{wptr_r, rptr_r, count_r} <= '0;
		else if (flush_in)
			{wptr_r, rptr_r, count_r} <= '0;
		else
		begin
			// Pointers wrap at the configured depth
			if (push)
				wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
			if (pop)
				rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule : rhg_fifo

// Health test and output gate for the physical random generator
module rhg_gate #(
	parameter int unsigned SAMPLE_DIV = rhg_pkg::RHG_SAMPLE_DIV,
	parameter int unsigned FIFO_DEPTH = rhg_pkg::RHG_FIFO_DEPTH
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  raw_bit_in,
	input  wire logic                  rng_start_in,
	input  wire logic                  hwtest_start_in,
	output logic                       rd_valid_out,
	input  wire logic                  rd_ready_in,
	output logic [rhg_pkg::RHG_OCTET_W-1:0] rd_data_out,
	output rhg_pkg::rhg_status_s       status_out,
	output rhg_pkg::rhg_hwtest_s       hwtest_out
);
	import rhg_pkg::*;

	rhg_state_e           state_r;      // Gate state
	logic                 raw_s1_r;     // Synchroniser first stage
	logic                 raw_s2_r;     // Synchronised raw bit
	logic [RHG_DIV_W-1:0] div_r;        // Sample spacing counter
	logic                 tick;         // One raw bit sampled
	logic                 last_bit_r;   // Previous sampled bit
	logic [RHG_RUN_W-1:0] run_r;        // Current run length
	logic [RHG_WIN_W-1:0] win_r;        // Bits seen in window
	logic [RHG_WIN_W-1:0] ones_r;       // Ones seen in window
	logic [RHG_WIN_W-1:0] ones_now;     // Ones including this bit
	logic                 dead_evt;     // Run limit reached
	logic                 win_end;      // Window closes now
	logic                 win_bad;      // Window out of band
	logic                 total_fail_r; // Latched dead source
	logic                 online_fail_r;// Latched statistical defect
	logic                 powerup_ok_r; // Power-up window passed
	logic                 testing;      // Health tests active
	logic [RHG_DLY_W-1:0] dly_r;        // Release delay line
	logic [RHG_RUN_W:0]   fill_r;       // Delay line fill level
	logic [2:0]           bitcnt_r;     // Bits into current octet
	logic                 oct_push;     // Octet offered to buffer
	logic                 buf_ready;    // Buffer has room
	logic                 buf_valid;    // Buffer holds an octet
	logic                 shift_en;     // Assembly may take a bit
	logic [RHG_HWT_W-1:0] hwt_cnt_r;    // Failure test bit count
	logic                 hwt_busy_r;   // Failure test running
	logic                 hwt_bad_r;    // Failure seen in test
	logic                 hwt_done_r;   // Failure test finished
	logic                 hwt_pass_r;   // Failure test result

	// Entropy pin is asynchronous: two flops before any use
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			{raw_s2_r, raw_s1_r} <= 2'h0;
		else
			{raw_s2_r, raw_s1_r} <= {raw_s1_r, raw_bit_in};
	end

	// Sample divider keeps successive raw bits apart
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			div_r <= '0;
		else
			div_r <= tick ? '0 : div_r + 1'b1;
	end

	assign tick    = (div_r == RHG_DIV_W'(SAMPLE_DIV-1));
	assign testing = (state_r == RHG_POWERUP) || (state_r == RHG_RUN);

	// dead source check, run of identical bits
	assign dead_evt = testing && tick && (raw_s2_r == last_bit_r)
		&& (run_r == RHG_RUN_W'(RHG_RUN_LIMIT-1));
	// ones count judged at each window end
	assign ones_now = ones_r + RHG_WIN_W'(raw_s2_r);
	assign win_end  = testing && tick
		&& (win_r == RHG_WIN_W'(RHG_WIN_BITS-1));
	assign win_bad  = (ones_now < RHG_WIN_W'(RHG_ONES_LO))
		|| (ones_now > RHG_WIN_W'(RHG_ONES_HI));

	// Run length tracker, restarted with the generator
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			{last_bit_r, run_r} <= '0;
		else if (rng_start_in)
			{last_bit_r, run_r} <= '0;
		else if (testing && tick)
		begin
			last_bit_r <= raw_s2_r;
			// Same bit extends the run, saturating at the limit
			if (raw_s2_r != last_bit_r)
				run_r <= RHG_RUN_W'(1);
			else if (run_r != RHG_RUN_W'(RHG_RUN_LIMIT))
				run_r <= run_r + 1'b1;
		end
	end

	// windows follow back to back, so testing never pauses
	// a defect is caught by the end of the first whole window after its onset
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			{win_r, ones_r} <= '0;
		else if (rng_start_in || win_end)
			{win_r, ones_r} <= '0;
		else if (testing && tick)
		begin
			win_r  <= win_r + 1'b1;
			ones_r <= ones_now;
		end
	end

	// Gate state machine
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_r <= rhg_state_e'(RHG_ST_RESET);
		else if (rng_start_in)
			state_r <= RHG_POWERUP;
		else
		begin
			unique case (state_r)
				RHG_IDLE:
					state_r <= RHG_IDLE;
				// only a clean first window opens the gate
				RHG_POWERUP:
					if (dead_evt || (win_end && win_bad))
						state_r <= RHG_FAIL;
					else if (win_end)
						state_r <= RHG_RUN;
				// any defect while running closes the gate
				RHG_RUN:
					if (dead_evt || (win_end && win_bad))
						state_r <= RHG_FAIL;
				// only a restart leaves the failed state
				RHG_FAIL:
					state_r <= RHG_FAIL;
			endcase
		end
	end

	// Sticky health flags; a new failure wins over the restart clear, which wins over a power-up pass
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			total_fail_r  <= 1'b0;
			online_fail_r <= 1'b0;
			powerup_ok_r  <= 1'b0;
		end
		else
		begin
			// a dead source latches and blocks output
			total_fail_r  <= dead_evt || (total_fail_r && !rng_start_in);
			online_fail_r <= (win_end && win_bad)
				|| (online_fail_r && !rng_start_in);
			if (rng_start_in)
				powerup_ok_r <= 1'b0;
			else if ((state_r == RHG_POWERUP) && win_end && !win_bad
				&& !dead_evt)
				powerup_ok_r <= 1'b1;
		end
	end

	// Assembly halts while the buffer is full, the tests do not
	assign shift_en = testing && tick && buf_ready && !dead_evt;

	// bits wait a full run length before release, so a dead
	// source is flagged before any of its bits reach an octet
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			{dly_r, fill_r, bitcnt_r} <= '0;
		// Held bits are discarded, never released; a full buffer
		// restarts ageing so every octet is one unbroken slice
		else if (rng_start_in || !testing || dead_evt
			|| (tick && !buf_ready))
			{dly_r, fill_r, bitcnt_r} <= '0;
		else if (shift_en)
		begin
			dly_r <= {dly_r[RHG_DLY_W-2:0], raw_s2_r};
			if (fill_r != (RHG_RUN_W+1)'(RHG_RUN_LIMIT))
				fill_r <= fill_r + 1'b1;
			else
				bitcnt_r <= bitcnt_r + 1'b1;
		end
	end

	// one octet offered per eight aged bits
	assign oct_push = shift_en && (bitcnt_r == 3'h7)
		&& (fill_r == (RHG_RUN_W+1)'(RHG_RUN_LIMIT));

	// Octet buffer between the tests and software
	rhg_fifo #(
		.WIDTH (RHG_OCTET_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in   (sys_clk_in),
		.rst_in       (rst_in),
		.flush_in     (state_r != RHG_RUN),
		.wr_valid_in  (oct_push),
		.wr_ready_out (buf_ready),
		.wr_data_in   (dly_r[RHG_DLY_W-2:RHG_DLY_W-1-RHG_OCTET_W]),
		.rd_valid_out (buf_valid),
		.rd_ready_in  (rd_ready_in && (state_r == RHG_RUN)),
		.rd_data_out  (rd_data_out)
	);

	// valid only in run state with no latched failure
	assign rd_valid_out = buf_valid && (state_r == RHG_RUN)
		&& !total_fail_r && !online_fail_r;

	// software started failure test over a fixed bit count
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hwt_busy_r <= 1'b0;
			hwt_bad_r  <= 1'b0;
			hwt_done_r <= 1'b0;
			hwt_pass_r <= 1'b0;
			hwt_cnt_r  <= '0;
		end
		else if (hwtest_start_in)
		begin
			// A start while idle or failed reports fail at once
			hwt_busy_r <= testing;
			hwt_bad_r  <= 1'b0;
			hwt_done_r <= !testing;
			hwt_pass_r <= 1'b0;
			hwt_cnt_r  <= '0;
		end
		else if (hwt_busy_r)
		begin
			if (dead_evt || !testing)
				hwt_bad_r <= 1'b1;
			if (tick)
				hwt_cnt_r <= hwt_cnt_r + 1'b1;
			if (tick && (hwt_cnt_r == RHG_HWT_W'(RHG_HWT_BITS-1)))
			begin
				hwt_busy_r <= 1'b0;
				hwt_done_r <= 1'b1;
				hwt_pass_r <= !hwt_bad_r && !dead_evt && testing;
			end
		end
	end

	// Status words for software
	assign status_out = '{total_fail:   total_fail_r,
		online_fail:  online_fail_r,
		powerup_done: powerup_ok_r,
		out_enable:   (state_r == RHG_RUN)};
	assign hwtest_out = '{busy: hwt_busy_r, done: hwt_done_r,
		pass: hwt_pass_r};

endmodule : rhg_gate

// >>> logic/rhg_pkg.sv
// Shared constants and types for the random generator health gate
package rhg_pkg;

	// Octet width of released random values
	localparam int unsigned RHG_OCTET_W     = 8;
	// Clocks between two samples of the raw entropy pin
	localparam int unsigned RHG_SAMPLE_DIV  = 8;
	// Identical raw bits in a row that mean a dead source
	localparam int unsigned RHG_RUN_LIMIT   = 32;
	// Raw bits per statistical test window
	localparam int unsigned RHG_WIN_BITS    = 256;
	// Accepted band for the count of ones in one window
	localparam int unsigned RHG_ONES_LO     = 100;
	localparam int unsigned RHG_ONES_HI     = 156;
	// Raw bits observed by a software started failure test
	localparam int unsigned RHG_HWT_BITS    = 64;
	// Depth of the output octet buffer
	localparam int unsigned RHG_FIFO_DEPTH  = 8;

	// Counter widths derived from the figures above
	localparam int unsigned RHG_DIV_W  = $clog2(RHG_SAMPLE_DIV);
	localparam int unsigned RHG_RUN_W  = $clog2(RHG_RUN_LIMIT + 1);
	localparam int unsigned RHG_WIN_W  = $clog2(RHG_WIN_BITS + 1);
	localparam int unsigned RHG_HWT_W  = $clog2(RHG_HWT_BITS + 1);
	// Release delay line: bits held back before they may leave
	localparam int unsigned RHG_DLY_W  = RHG_RUN_LIMIT + RHG_OCTET_W;

	// Reset value of the state register
	localparam logic [1:0]  RHG_ST_RESET = 2'h0;

	// Gate state, Gray coded along idle, power-up, run, fail
	typedef enum logic [1:0] {
		RHG_IDLE    = 2'h0,
		RHG_POWERUP = 2'h1,
		RHG_RUN     = 2'h3,
		RHG_FAIL    = 2'h2
	} rhg_state_e;

	// Health status seen by software
	typedef struct packed {
		logic total_fail;   // Dead entropy source latched
		logic online_fail;  // Statistical defect latched
		logic powerup_done; // Power-up test passed
		logic out_enable;   // Random output currently allowed
	} rhg_status_s;

	// Result of the software started failure test
	typedef struct packed {
		logic busy; // Test still running
		logic done; // Result below is valid
		logic pass; // Source looked alive
	} rhg_hwtest_s;

endpackage : rhg_pkg

// >>> testbench/rhg_gate_props.sv
// Checker for the health gated random octet source
module rhg_gate_props
	import rhg_pkg::*;
#(
	parameter int unsigned SAMPLE_DIV = rhg_pkg::RHG_SAMPLE_DIV
) (
	input wire logic                          sys_clk_in,
	input wire logic                          rst_in,
	input wire logic                          raw_bit_in,
	input wire logic                          rng_start_in,
	input wire logic                          hwtest_start_in,
	input wire logic                          rd_valid_out,
	input wire logic                          rd_ready_in,
	input wire logic [rhg_pkg::RHG_OCTET_W-1:0] rd_data_out,
	input wire rhg_pkg::rhg_status_s          status_out,
	input wire rhg_pkg::rhg_hwtest_s          hwtest_out
);
	import rhg_pkg::*;
	// Bounds on the two timed answers, with margin for the synchroniser
	localparam int HWT_MAX = (RHG_HWT_BITS + 4) * SAMPLE_DIV + 8;
	localparam int PU_MAX  = (RHG_WIN_BITS + 8) * SAMPLE_DIV + 16;
	int unsigned pu_cnt_r; // Cycles since start without a verdict

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// Power-up wait counter, stops at any verdict
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			pu_cnt_r <= 0;
		else if (rng_start_in)
			pu_cnt_r <= 1;
		else if (pu_cnt_r != 0 && !status_out.powerup_done &&
			!status_out.total_fail && !status_out.online_fail)
			pu_cnt_r <= pu_cnt_r + 1;
		else
			pu_cnt_r <= 0;
	end

	a_valid_gated: assert property (
		rd_valid_out |-> status_out.out_enable && status_out.powerup_done &&
		!status_out.total_fail && !status_out.online_fail)
		else $error("octet offered while gate closed");
	a_fail_closes: assert property (
		(status_out.total_fail || status_out.online_fail)
		|-> !status_out.out_enable)
		else $error("output enabled with failure latched");
	a_total_sticky: assert property (
		status_out.total_fail && !rng_start_in |=> status_out.total_fail)
		else $error("dead source flag lost without restart");
	a_online_sticky: assert property (
		status_out.online_fail && !rng_start_in |=> status_out.online_fail)
		else $error("defect flag lost without restart");
	a_start_closes: assert property (
		rng_start_in |=> !rd_valid_out && !status_out.out_enable &&
		!status_out.powerup_done)
		else $error("restart left the gate open");
	a_data_hold: assert property (
		rd_valid_out && !rd_ready_in |=> !rd_valid_out || $stable(rd_data_out))
		else $error("octet changed before it was taken");
	a_powerup_bound: assert property (
		pu_cnt_r < PU_MAX)
		else $error("power-up test gave no verdict in time");
	a_hwt_answer: assert property (
		hwtest_start_in |=> hwtest_out.busy ||
		(hwtest_out.done && !hwtest_out.pass))
		else $error("failure test start not answered");
	a_hwt_bound: assert property (
		$rose(hwtest_out.busy) |-> ##[1:HWT_MAX]
		(!hwtest_out.busy && hwtest_out.done))
		else $error("failure test did not finish in time");
endmodule : rhg_gate_props

bind rhg_gate rhg_gate_props #(.SAMPLE_DIV(SAMPLE_DIV)) rhg_gate_props_inst (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .raw_bit_in(raw_bit_in),
	.rng_start_in(rng_start_in), .hwtest_start_in(hwtest_start_in),
	.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
	.rd_data_out(rd_data_out), .status_out(status_out),
	.hwtest_out(hwtest_out)
);

// >>> testbench/tb_top.sv
// Self-checking bench for the random generator health gate
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rhg_pkg::*;
	localparam int DIV = 2; // Short sample period keeps the run brief
	logic                   sys_clk_in, rst_in, raw_bit_in, rng_start_in;
	logic                   hwtest_start_in, rd_ready_in, rd_valid_out;
	logic [RHG_OCTET_W-1:0] rd_data_out;
	rhg_status_s            status_out;
	rhg_hwtest_s            hwtest_out;
	int                     n_errors, num_checks, oct_cnt;
	int                     mode, ph, pat; // Raw source pattern and phase
	bit                     synced;        // Model has found the offset
	bit                     sent_q[$];     // Every raw bit handed in
	int                     cands[$];      // Offsets still consistent

	rhg_gate #(.SAMPLE_DIV(DIV), .FIFO_DEPTH(RHG_FIFO_DEPTH)) rhg_gate_inst (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .raw_bit_in(raw_bit_in),
		.rng_start_in(rng_start_in), .hwtest_start_in(hwtest_start_in),
		.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
		.rd_data_out(rd_data_out), .status_out(status_out),
		.hwtest_out(hwtest_out));

	// Free running clock
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// One raw bit per sample period, so each bit is sampled once
	always @(posedge sys_clk_in)
	begin
		ph = (ph + 1) % DIV;
		if (ph == 0)
		begin
			pat++;
			sent_q.push_back(mode == 0 ? $urandom() % 2 :
				mode == 1 ? 1'b1 : (pat % 4 != 0));
			raw_bit_in <= sent_q[$];
		end
	end

	// Octet taken at every valid and ready edge
	always @(posedge sys_clk_in)
		if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
			take_octet(rd_data_out);

	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Octet built from raw bits, oldest bit in the top place
	function automatic logic [7:0] oct_at(int i);
		logic [7:0] v;
		for (int k = 0; k < 8; k++)
			v[7-k] = sent_q[i+k];
		return v;
	endfunction : oct_at

	// Stream model: octets must be adjacent slices of the raw stream
	task automatic take_octet(input logic [7:0] d);
		int keep[$];
		logic [7:0] exp;
		oct_cnt++;
		if (synced)
		begin
			exp = oct_at(cands[0]);
			foreach (cands[i])
				if (oct_at(cands[i]) === d)
					keep.push_back(cands[i] + 8);
			if (keep.size() != 0)
				exp = oct_at(keep[0] - 8);
			chk(d, exp);
		end
		else
			for (int i = 0; i + 8 <= sent_q.size(); i++)
				if (oct_at(i) === d)
					keep.push_back(i + 8);
		cands = keep;
		synced = (keep.size() != 0);
	endtask : take_octet

	// Bounded wait for one status bit; running out ends the run
	task automatic wait_for(input int which, input int limit);
		logic [3:0] v;
		for (int i = 0; i < limit; i++)
		begin
			@(posedge sys_clk_in);
			#1;
			v = {hwtest_out.done, status_out.online_fail,
				status_out.total_fail, status_out.powerup_done};
			if (v[which] === 1'b1)
				return;
		end
		chk(8'h00, 8'h01);
		results();
	endtask : wait_for

	task automatic start(input int m);
		mode = m;
		synced = 0;
		@(posedge sys_clk_in) rng_start_in <= 1'b1;
		@(posedge sys_clk_in) rng_start_in <= 1'b0;
	endtask : start

	task automatic hw_test(input logic [2:0] exp);
		@(posedge sys_clk_in) hwtest_start_in <= 1'b1;
		@(posedge sys_clk_in) hwtest_start_in <= 1'b0;
		wait_for(3, (RHG_HWT_BITS + 8) * DIV);
		chk(8'(hwtest_out), 8'(exp));
	endtask : hw_test

	// Main sequence
	initial
	begin
		rst_in = 1'b1;
		{raw_bit_in, rng_start_in, hwtest_start_in, rd_ready_in} = 4'h0;
		void'($urandom(32'h1FBA));
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
		chk(8'({status_out, hwtest_out, rd_valid_out}), 8'h00);
		hw_test(3'b010);
		// dead source at start never releases octets
		oct_cnt = 0;
		rd_ready_in <= 1'b1;
		start(1);
		wait_for(1, (RHG_RUN_LIMIT + 4) * DIV);
		repeat (100 * DIV) @(posedge sys_clk_in);
		chk(8'(oct_cnt), 8'h00);
		start(0);
		wait_for(0, (RHG_WIN_BITS + 8) * DIV);
		chk(8'(status_out), 8'h03);
		oct_cnt = 0;
		repeat (200 * DIV) @(posedge sys_clk_in);
		chk(8'(oct_cnt >= 20), 8'h01);
		hw_test(3'b011);
		// Buffer filled while the reader stalls, then drained
		rd_ready_in <= 1'b0;
		repeat ((RHG_FIFO_DEPTH + 4) * 8 * DIV) @(posedge sys_clk_in);
		oct_cnt = 0;
		rd_ready_in <= 1'b1;
		repeat (RHG_FIFO_DEPTH) @(posedge sys_clk_in);
		rd_ready_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
		chk(8'({oct_cnt[3:0], rd_valid_out}), 8'h10);
		synced = 0;
		rd_ready_in <= 1'b1;
		// biased stream caught within two windows
		repeat (50 * DIV) @(posedge sys_clk_in);
		mode = 2;
		wait_for(2, (2 * RHG_WIN_BITS + 16) * DIV);
		chk(8'({status_out.out_enable, rd_valid_out}), 8'h00);
		// restart clears flags and passes again
		start(0);
		wait_for(0, (RHG_WIN_BITS + 8) * DIV);
		chk(8'(status_out), 8'h03);
		repeat (100 * DIV) @(posedge sys_clk_in);
		mode = 1;
		wait_for(1, (RHG_RUN_LIMIT + 4) * DIV);
		chk(8'({status_out.out_enable, rd_valid_out}), 8'h00);
		results();
	end
endmodule : tb_top
